/* core/acr_regs.sv */
/*
 * channel configuration and calibration register bank with ahb-lite slave.
 * assumes a single ahb-lite master, word transfers, clk_sys at 25 MHz,
 * synchronous active-high reset, and samples from the same clock domain.
 */
// What this block does
// - config bits 15:6 hold signed phase delay
// - config bits 5:3 read zero, ignore writes
// - bypass bit 2 turns channel dc-block off
// - input select routes own, shorted, test +/-
// - offset high register holds offset bits 23:8
// - offset low 15:8 data, 7:0 read zero
// - gain is 24-bit unsigned from two registers
// - gain high register resets to unity 8000h
// - gain low 15:8 data, 7:0 read zero
// - channel config words reset to all zeros
// - global dc setting is 4 bits 3:0
`timescale 1ns/100ps
module acr_regs (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire acr_pkg::acr_sample_t chan0_sample_in,
    output acr_pkg::acr_sample_t chan0_sample_out,
    output logic [9:0] chan0_phase_delay,
    output logic chan0_dc_filter_bypass,
    output logic [1:0] chan0_input_select,
    output logic [acr_pkg::ROUTE_W-1:0] chan0_input_route,
    output logic chan0_dc_filter_on,
    output logic [9:0] chan1_phase_delay,
    output logic chan1_dc_filter_bypass,
    output logic [1:0] chan1_input_select,
    output logic [acr_pkg::ROUTE_W-1:0] chan1_input_route,
    output logic chan1_dc_filter_on,
    output logic [acr_pkg::DC_W-1:0] global_dc_filter_setting,
    output logic [acr_pkg::CAL_W-1:0] chan0_offset_word,
    output logic [acr_pkg::CAL_W-1:0] chan0_gain_word
);

    localparam int RW = acr_pkg::REG_W;
    localparam int LO = acr_pkg::CAL_LO_LSB;
    localparam acr_pkg::acr_chan_cfg_t CFG_RST_FIELDS = acr_pkg::CFG_RST;

    acr_pkg::acr_chan_cfg_t cfg0_reg;
    acr_pkg::acr_chan_cfg_t cfg0_next;
    acr_pkg::acr_chan_cfg_t cfg1_reg;
    acr_pkg::acr_chan_cfg_t cfg1_next;
    logic [RW-1:0] ofs_hi_reg;
    logic [RW-1:0] ofs_hi_next;
    logic [RW-1:0] ofs_lo_reg;
    logic [RW-1:0] ofs_lo_next;
    logic [RW-1:0] gain_hi_reg;
    logic [RW-1:0] gain_hi_next;
    logic [RW-1:0] gain_lo_reg;
    logic [RW-1:0] gain_lo_next;
    logic [RW-1:0] gdc_reg;
    logic [RW-1:0] gdc_next;
    logic [acr_pkg::ROUTE_W-1:0] route0_reg;
    logic [acr_pkg::ROUTE_W-1:0] route0_next;
    logic [acr_pkg::ROUTE_W-1:0] route1_reg;
    logic [acr_pkg::ROUTE_W-1:0] route1_next;
    logic filt_on0_reg;
    logic filt_on0_next;
    logic filt_on1_reg;
    logic filt_on1_next;
    logic [31:0] hrdata_reg;
    logic [31:0] hrdata_next;
    logic wr_pend_reg;
    logic [acr_pkg::IDX_W-1:0] wr_idx_reg;
    logic addr_take;
    logic addr_in_range;
    logic [acr_pkg::IDX_W-1:0] addr_idx;
    logic [RW-1:0] wdata;
    logic wr_cfg0;
    logic wr_cfg1;
    logic wr_ofs_hi;
    logic wr_ofs_lo;
    logic wr_gain_hi;
    logic wr_gain_lo;
    logic wr_gdc;
    logic [RW-1:0] rd_word;
    logic [RW-1:0] res_hi_word;
    logic [RW-1:0] res_lo_word;
    acr_pkg::acr_sample_t cal_out;

    // address phase decode; word index from the byte address
    assign addr_take = hsel && hready && htrans[acr_pkg::HTRANS_ACTIVE_BIT];
    assign addr_in_range = (haddr[31:acr_pkg::IDX_W+2] == '0);
    assign addr_idx = haddr[acr_pkg::IDX_W+1:2];
    assign wdata = hwdata[RW-1:0];

    // data phase write strobes, one per stored register
    assign wr_cfg0 = wr_pend_reg && (wr_idx_reg == acr_pkg::IDX_CHAN0_CONFIG);
    assign wr_cfg1 = wr_pend_reg && (wr_idx_reg == acr_pkg::IDX_CHAN1_CONFIG);
    assign wr_ofs_hi = wr_pend_reg && (wr_idx_reg == acr_pkg::IDX_CH0_OFS_HI);
    assign wr_ofs_lo = wr_pend_reg && (wr_idx_reg == acr_pkg::IDX_CH0_OFS_LO);
    assign wr_gain_hi = wr_pend_reg && (wr_idx_reg == acr_pkg::IDX_CH0_GAIN_HI);
    assign wr_gain_lo = wr_pend_reg && (wr_idx_reg == acr_pkg::IDX_CH0_GAIN_LO);
    assign wr_gdc = wr_pend_reg && (wr_idx_reg == acr_pkg::IDX_GLOBAL_DC);

    // next register values; reserved bits masked off on every write
    assign cfg0_next = wr_cfg0 ? (wdata & acr_pkg::CFG_WMASK) : cfg0_reg;
    assign cfg1_next = wr_cfg1 ? (wdata & acr_pkg::CFG_WMASK) : cfg1_reg;
    assign ofs_hi_next = wr_ofs_hi ? wdata : ofs_hi_reg;
    assign ofs_lo_next = wr_ofs_lo ? (wdata & acr_pkg::LO_WMASK) : ofs_lo_reg;
    assign gain_hi_next = wr_gain_hi ? wdata : gain_hi_reg;
    assign gain_lo_next = wr_gain_lo ? (wdata & acr_pkg::LO_WMASK) : gain_lo_reg;
    assign gdc_next = wr_gdc ? (wdata & acr_pkg::GLOBAL_DC_WMASK) : gdc_reg;

    // one-hot input routing from the select code
    assign route0_next = acr_pkg::ROUTE_W'(1) << cfg0_next.input_select;
    assign route1_next = acr_pkg::ROUTE_W'(1) << cfg1_next.input_select;

    // dc blocking enables, kept in flops so the outputs come straight from them
    assign filt_on0_next = !cfg0_next.dc_filter_bypass;
    assign filt_on1_next = !cfg1_next.dc_filter_bypass;

    // latest corrected result, split like the calibration registers
    assign res_hi_word = cal_out.data[acr_pkg::CAL_W-1:LO];
    assign res_lo_word = {cal_out.data[LO-1:0], {LO{1'b0}}};

    // read select from next values so a write just before is seen
    assign rd_word = !addr_in_range ? '0 :
        (addr_idx == acr_pkg::IDX_CHAN0_CONFIG) ? RW'(cfg0_next) :
        (addr_idx == acr_pkg::IDX_CHAN1_CONFIG) ? RW'(cfg1_next) :
        (addr_idx == acr_pkg::IDX_CH0_OFS_HI) ? ofs_hi_next :
        (addr_idx == acr_pkg::IDX_CH0_OFS_LO) ? ofs_lo_next :
        (addr_idx == acr_pkg::IDX_CH0_GAIN_HI) ? gain_hi_next :
        (addr_idx == acr_pkg::IDX_CH0_GAIN_LO) ? gain_lo_next :
        (addr_idx == acr_pkg::IDX_GLOBAL_DC) ? gdc_next :
        (addr_idx == acr_pkg::IDX_CH0_RES_HI) ? res_hi_word :
        (addr_idx == acr_pkg::IDX_CH0_RES_LO) ? res_lo_word : '0;
    assign hrdata_next = (addr_take && !hwrite) ? {{(32-RW){1'b0}}, rd_word} : hrdata_reg;

    // bus handshake state: pending write and its target
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            wr_pend_reg <= 1'b0;
            wr_idx_reg <= '0;
            hrdata_reg <= '0;
        end
        else
        begin
            wr_pend_reg <= addr_take && hwrite && addr_in_range;
            wr_idx_reg <= addr_take ? addr_idx : wr_idx_reg;
            hrdata_reg <= hrdata_next;
        end
    end

    // channel configuration registers, their routing and the global dc setting
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            cfg0_reg <= acr_pkg::CFG_RST;
            cfg1_reg <= acr_pkg::CFG_RST;
            route0_reg <= acr_pkg::ROUTE_W'(1) << acr_pkg::SEL_OWN_PAIR;
            route1_reg <= acr_pkg::ROUTE_W'(1) << acr_pkg::SEL_OWN_PAIR;
            gdc_reg <= acr_pkg::GLOBAL_DC_RST;
        end
        else
        begin
            cfg0_reg <= cfg0_next;
            cfg1_reg <= cfg1_next;
            route0_reg <= route0_next;
            route1_reg <= route1_next;
            gdc_reg <= gdc_next;
        end
    end

    // per-channel dc blocking enables; bypass clear leaves the global setting in charge
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            filt_on0_reg <= !CFG_RST_FIELDS.dc_filter_bypass;
            filt_on1_reg <= !CFG_RST_FIELDS.dc_filter_bypass;
        end
        else
        begin
            filt_on0_reg <= filt_on0_next;
            filt_on1_reg <= filt_on1_next;
        end
    end

    // calibration registers
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            ofs_hi_reg <= acr_pkg::OFS_RST;
            ofs_lo_reg <= acr_pkg::OFS_RST;
            gain_hi_reg <= acr_pkg::GAIN_HI_RST;
            gain_lo_reg <= acr_pkg::GAIN_LO_RST;
        end
        else
        begin
            ofs_hi_reg <= ofs_hi_next;
            ofs_lo_reg <= ofs_lo_next;
            gain_hi_reg <= gain_hi_next;
            gain_lo_reg <= gain_lo_next;
        end
    end

    // outputs taken straight from the registers; bus ready and response are tied to constants
    assign hrdata = hrdata_reg;
    assign hreadyout = 1'b1; // zero wait states
    assign hresp = 1'b0; // always okay
    assign chan0_phase_delay = cfg0_reg.phase_delay;
    assign chan0_dc_filter_bypass = cfg0_reg.dc_filter_bypass;
    assign chan0_dc_filter_on = filt_on0_reg;
    assign chan0_input_select = cfg0_reg.input_select;
    assign chan0_input_route = route0_reg;
    assign chan1_phase_delay = cfg1_reg.phase_delay;
    assign chan1_dc_filter_bypass = cfg1_reg.dc_filter_bypass;
    assign chan1_dc_filter_on = filt_on1_reg;
    assign chan1_input_select = cfg1_reg.input_select;
    assign chan1_input_route = route1_reg;
    assign global_dc_filter_setting = gdc_reg[acr_pkg::DC_W-1:0];
    assign chan0_offset_word = {ofs_hi_reg, ofs_lo_reg[RW-1:LO]};
    assign chan0_gain_word = {gain_hi_reg, gain_lo_reg[RW-1:LO]};
    assign chan0_sample_out = cal_out;

    // correction of channel 0 results
    acr_cal_apply #(
        .DATA_W(acr_pkg::CAL_W)
    ) u_cal0 (
        .clk_sys(clk_sys),
        .rst(rst),
        .sample_in(chan0_sample_in),
        .offset_word(chan0_offset_word),
        .gain_word(chan0_gain_word),
        .sample_out(cal_out)
    );

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_phase_write_taken: assert property (
        wr_cfg0 |=> chan0_phase_delay == $past(hwdata[RW-1:6]))
        else $error("phase delay not taken from write data");
    a_cfg_rsvd_zero: assert property (
        (addr_take && !hwrite && (addr_idx == acr_pkg::IDX_CHAN0_CONFIG
        || addr_idx == acr_pkg::IDX_CHAN1_CONFIG)) |=> hrdata[5:3] == 3'h0)
        else $error("reserved configuration bits read nonzero");
    a_bypass_dc_off: assert property (
        (wr_cfg1 && hwdata[2]) |=> !chan1_dc_filter_on && chan1_dc_filter_bypass)
        else $error("bypass write did not turn dc blocking off");
    a_route_from_sel: assert property (
        $rose(route0_reg[acr_pkg::ROUTE_NEG])
        |-> chan0_input_select == acr_pkg::SEL_TEST_NEG && $onehot(route0_reg))
        else $error("input route disagrees with select");
    a_ofs_upper_word: assert property (
        wr_ofs_hi |=> chan0_offset_word[acr_pkg::CAL_W-1:LO] == $past(hwdata[RW-1:0]))
        else $error("offset upper bits not from high register write");
    a_ofs_low_rsvd: assert property (
        (addr_take && !hwrite && addr_idx == acr_pkg::IDX_CH0_OFS_LO
        && addr_in_range) |=> hrdata[LO-1:0] == 8'h00)
        else $error("offset low reserved byte read nonzero");
    a_gain_low_join: assert property (
        wr_gain_lo |=> chan0_gain_word[LO-1:0] == $past(hwdata[RW-1:LO])
        && $stable(chan0_gain_word[acr_pkg::CAL_W-1:LO]))
        else $error("gain low write did not land in bits 7:0 alone");
    a_gain_reset_unity: assert property (
        $past(rst) |-> chan0_gain_word == acr_pkg::GAIN_UNITY)
        else $error("gain not unity after reset");
    a_gain_low_rsvd: assert property (
        (addr_take && !hwrite && addr_idx == acr_pkg::IDX_CH0_GAIN_LO
        && addr_in_range) |=> hrdata[LO-1:0] == 8'h00)
        else $error("gain low reserved byte read nonzero");
    a_cfg_reset_zero: assert property (
        $past(rst) |-> chan0_phase_delay == '0 && chan1_input_select == '0
        && chan0_dc_filter_on && chan1_input_route[acr_pkg::ROUTE_OWN])
        else $error("configuration not zero after reset");
    a_gdc_width_four: assert property (
        wr_gdc |=> global_dc_filter_setting == $past(hwdata[acr_pkg::DC_W-1:0])
        ##1 hrdata[RW-1:acr_pkg::DC_W] == '0
        || !$past(addr_take && !hwrite && addr_idx == acr_pkg::IDX_GLOBAL_DC))
        else $error("global dc setting not taken as four bits");
    a_ofs_low_join: assert property (
        wr_ofs_lo |=> chan0_offset_word[LO-1:0] == $past(hwdata[RW-1:LO])
        && $stable(chan0_offset_word[acr_pkg::CAL_W-1:LO]))
        else $error("offset low write did not land in bits 7:0 alone");
    a_gain_upper_word: assert property (
        wr_gain_hi |=> chan0_gain_word[acr_pkg::CAL_W-1:LO] == $past(hwdata[RW-1:0]))
        else $error("gain upper bits not from high register write");
    a_route1_onehot: assert property (
        $onehot(chan1_input_route) && chan1_input_route[chan1_input_select])
        else $error("channel 1 route disagrees with select");
    a_dc_on_inverse: assert property (
        chan0_dc_filter_on == !chan0_dc_filter_bypass
        && chan1_dc_filter_on == !chan1_dc_filter_bypass)
        else $error("dc blocking enable disagrees with bypass");
    a_result_hi_read: assert property (
        (addr_take && !hwrite && addr_in_range && addr_idx == acr_pkg::IDX_CH0_RES_HI)
        |=> hrdata[RW-1:0] == $past(cal_out.data[acr_pkg::CAL_W-1:LO]))
        else $error("result upper word read back wrong");
    a_result_lo_read: assert property (
        (addr_take && !hwrite && addr_in_range && addr_idx == acr_pkg::IDX_CH0_RES_LO)
        |=> hrdata[RW-1:LO] == $past(cal_out.data[LO-1:0]) && hrdata[LO-1:0] == '0)
        else $error("result lower word read back wrong");

endmodule

/* core/acr_pkg.sv */
/*
 * constants, register indexes and carrier types for the channel
 * configuration and calibration register bank.
 * assumes a 32-bit ahb-lite register bus with one register per word.
 */
package acr_pkg;

    // register width and calibration word layout
    localparam int REG_W = 16;
    localparam int CAL_W = 24;
    localparam int CAL_LO_LSB = 8;
    localparam int IDX_W = 8;
    localparam int DC_W = 4;
    localparam int ROUTE_W = 4;

    // register indexes; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_GLOBAL_DC = 8'h08;
    localparam logic [IDX_W-1:0] IDX_CHAN0_CONFIG = 8'h09;
    localparam logic [IDX_W-1:0] IDX_CH0_OFS_HI = 8'h0a;
    localparam logic [IDX_W-1:0] IDX_CH0_OFS_LO = 8'h0b;
    localparam logic [IDX_W-1:0] IDX_CH0_GAIN_HI = 8'h0c;
    localparam logic [IDX_W-1:0] IDX_CH0_GAIN_LO = 8'h0d;
    localparam logic [IDX_W-1:0] IDX_CHAN1_CONFIG = 8'h0e;
    localparam logic [IDX_W-1:0] IDX_CH0_RES_HI = 8'h20;
    localparam logic [IDX_W-1:0] IDX_CH0_RES_LO = 8'h21;

    // writable bit masks; reserved bits are never stored
    localparam logic [REG_W-1:0] CFG_WMASK = 16'hffc7;
    localparam logic [REG_W-1:0] LO_WMASK = 16'hff00;
    localparam logic [REG_W-1:0] GLOBAL_DC_WMASK = 16'h000f;

    // reset values
    localparam logic [REG_W-1:0] CFG_RST = 16'h0000;
    localparam logic [REG_W-1:0] OFS_RST = 16'h0000;
    localparam logic [REG_W-1:0] GAIN_HI_RST = 16'h8000;
    localparam logic [REG_W-1:0] GAIN_LO_RST = 16'h0000;
    localparam logic [REG_W-1:0] GLOBAL_DC_RST = 16'h0000;
    localparam logic [CAL_W-1:0] GAIN_UNITY = 24'h80_0000;
    localparam int GAIN_FRAC = 23;

    // input select codes
    localparam logic [1:0] SEL_OWN_PAIR = 2'h0;
    localparam logic [1:0] SEL_SHORTED = 2'h1;
    localparam logic [1:0] SEL_TEST_POS = 2'h2;
    localparam logic [1:0] SEL_TEST_NEG = 2'h3;

    // one-hot route bit positions
    localparam int ROUTE_OWN = 0;
    localparam int ROUTE_SHORT = 1;
    localparam int ROUTE_POS = 2;
    localparam int ROUTE_NEG = 3;

    // ahb transfer type bit that marks an active transfer
    localparam int HTRANS_ACTIVE_BIT = 1;

    // channel configuration word, bit for bit
    typedef struct packed {
        logic [9:0] phase_delay;
        logic [2:0] reserved;
        logic dc_filter_bypass;
        logic [1:0] input_select;
    } acr_chan_cfg_t;

    // one conversion result with its strobe
    typedef struct packed {
        logic valid;
        logic [CAL_W-1:0] data;
    } acr_sample_t;

endpackage

/* core/acr_cal_apply.sv */
/*
 * applies offset and gain correction to one channel's conversion results.
 * assumes samples arrive on clk_sys from logic in the same clock domain.
 */
`timescale 1ns/100ps
module acr_cal_apply #(
    parameter int DATA_W = acr_pkg::CAL_W
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire acr_pkg::acr_sample_t sample_in,
    input wire logic [DATA_W-1:0] offset_word,
    input wire logic [DATA_W-1:0] gain_word,
    output acr_pkg::acr_sample_t sample_out
);

    localparam int PROD_W = 2 * (DATA_W + 1);
    localparam logic signed [DATA_W-1:0] SAT_MAX = {1'b0, {(DATA_W-1){1'b1}}};
    localparam logic signed [DATA_W-1:0] SAT_MIN = {1'b1, {(DATA_W-1){1'b0}}};

    logic signed [DATA_W:0] diff;
    logic signed [DATA_W:0] gain_s;
    logic signed [PROD_W-1:0] product;
    logic signed [PROD_W-1:0] scaled;
    logic [DATA_W-1:0] sat_val;
    acr_pkg::acr_sample_t out_reg;
    acr_pkg::acr_sample_t out_next;

    // subtract offset, scale by gain with unity at the top bit, saturate
    assign diff = $signed({sample_in.data[DATA_W-1], sample_in.data})
        - $signed({offset_word[DATA_W-1], offset_word});
    assign gain_s = $signed({1'b0, gain_word});
    assign product = PROD_W'(diff) * PROD_W'(gain_s);
    assign scaled = product >>> acr_pkg::GAIN_FRAC;
    assign sat_val = (scaled > PROD_W'(SAT_MAX)) ? SAT_MAX :
        (scaled < PROD_W'(SAT_MIN)) ? SAT_MIN : scaled[DATA_W-1:0];
    assign out_next.valid = sample_in.valid;
    assign out_next.data = sample_in.valid ? sat_val : out_reg.data;
    assign sample_out = out_reg;

    // one cycle of latency, result held between strobes
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            out_reg <= '0;
        end
        else
        begin
            out_reg <= out_next;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_cal_strobe_lat: assert property (sample_in.valid |=> sample_out.valid)
        else $error("corrected sample strobe not one cycle after input");
    a_cal_unity_pass: assert property (
        (sample_in.valid && gain_word == acr_pkg::GAIN_UNITY && offset_word == '0)
        |=> sample_out.data == $past(sample_in.data))
        else $error("unity gain and zero offset altered the sample");
    a_cal_hold_idle: assert property (!sample_in.valid |=> $stable(sample_out.data))
        else $error("corrected sample changed without a strobe");

endmodule

/* verification/test_adc_channel_cal_config_regs.sv */
/*
 * self-checking bench for the channel configuration and calibration register bank.
 * assumes acr_pkg and acr_regs are compiled first; the bench acts as the one ahb-lite master.
 */
`timescale 1ns/100ps
module test_adc_channel_cal_config_regs;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    wire logic hready;
    acr_pkg::acr_sample_t chan0_sample_in = '0;
    acr_pkg::acr_sample_t chan0_sample_out;
    logic [9:0] chan0_phase_delay;
    logic [9:0] chan1_phase_delay;
    logic chan0_dc_filter_bypass;
    logic chan1_dc_filter_bypass;
    logic [1:0] chan0_input_select;
    logic [1:0] chan1_input_select;
    logic [acr_pkg::ROUTE_W-1:0] chan0_input_route;
    logic [acr_pkg::ROUTE_W-1:0] chan1_input_route;
    logic chan0_dc_filter_on;
    logic chan1_dc_filter_on;
    logic [acr_pkg::DC_W-1:0] global_dc_filter_setting;
    logic [acr_pkg::CAL_W-1:0] chan0_offset_word;
    logic [acr_pkg::CAL_W-1:0] chan0_gain_word;
    logic [15:0] mreg [0:255];
    logic [31:0] scratch;
    int miscompares = 0;
    int n_compared = 0;
    int seed = 32'h0000_0a72;

    // single slave, so its ready is the bus ready
    assign hready = hreadyout;

    acr_regs dut_u (
        .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .chan0_sample_in(chan0_sample_in), .chan0_sample_out(chan0_sample_out),
        .chan0_phase_delay(chan0_phase_delay), .chan0_dc_filter_bypass(chan0_dc_filter_bypass),
        .chan0_input_select(chan0_input_select), .chan0_input_route(chan0_input_route),
        .chan0_dc_filter_on(chan0_dc_filter_on), .chan1_phase_delay(chan1_phase_delay),
        .chan1_dc_filter_bypass(chan1_dc_filter_bypass),
        .chan1_input_select(chan1_input_select), .chan1_input_route(chan1_input_route),
        .chan1_dc_filter_on(chan1_dc_filter_on),
        .global_dc_filter_setting(global_dc_filter_setting),
        .chan0_offset_word(chan0_offset_word), .chan0_gain_word(chan0_gain_word)
    );

    // 25 MHz clock
    always #20 clk_sys = ~clk_sys;

    // verdict and end of run
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // one comparison, counted
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // writable bits per register index; unmapped keeps nothing
    function automatic logic [15:0] wmask(input logic [7:0] idx);
        case (idx)
            8'h08: return 16'h000f;
            8'h09, 8'h0e: return 16'hffc7;
            8'h0b, 8'h0d: return 16'hff00;
            8'h0a, 8'h0c: return 16'hffff;
            default: return 16'h0000;
        endcase
    endfunction

    // model of register contents after reset
    task automatic model_reset();
        for (int i = 0; i < 256; i++)
            mreg[i] = 16'h0000;
        mreg[12] = 16'h8000;
    endtask

    // offset removed, unsigned gain with unity at bit 23, saturated to 24 bits
    function automatic logic [23:0] corr(input logic [23:0] d, input logic [23:0] o,
                                         input logic [23:0] g);
        longint x;
        x = (longint'($signed(d)) - longint'($signed(o))) * longint'(g);
        x = x >>> 23;
        if (x > 64'sh0000_0000_007f_ffff)
            x = 64'sh0000_0000_007f_ffff;
        if (x < -64'sh0000_0000_0080_0000)
            x = -64'sh0000_0000_0080_0000;
        return x[23:0];
    endfunction

    // wait for ready at a rising edge; only the watchdog ends a stuck wait
    task automatic wait_ready();
        do
            @(posedge clk_sys);
        while (hready !== 1'b1);
    endtask

    // one single ahb-lite word transfer: address phase, then data phase
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                        output logic [31:0] rd);
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] rd;
        xfer(1'b1, {22'h00_0000, idx, 2'h0}, d, rd);
        mreg[idx] = d[15:0] & wmask(idx);
    endtask

    task automatic rdchk(input logic [7:0] idx);
        logic [31:0] rd;
        xfer(1'b0, {22'h00_0000, idx, 2'h0}, 32'h0000_0000, rd);
        chk($sformatf("reg %h", idx), rd, {16'h0000, mreg[idx]});
    endtask

    // all register-driven outputs against the model
    task automatic chk_outs();
        logic [15:0] a;
        logic [15:0] b;
        a = mreg[9];
        b = mreg[14];
        #1;
        chk("chan0_phase_delay", chan0_phase_delay, a[15:6]);
        chk("chan1_phase_delay", chan1_phase_delay, b[15:6]);
        chk("bypass0", chan0_dc_filter_bypass, a[2]);
        chk("bypass1", chan1_dc_filter_bypass, b[2]);
        chk("filter_on0", chan0_dc_filter_on, !a[2]);
        chk("filter_on1", chan1_dc_filter_on, !b[2]);
        chk("select0", chan0_input_select, a[1:0]);
        chk("select1", chan1_input_select, b[1:0]);
        chk("route0", chan0_input_route, 4'h1 << a[1:0]);
        chk("route1", chan1_input_route, 4'h1 << b[1:0]);
        chk("global_dc", global_dc_filter_setting, mreg[8][3:0]);
        chk("offset_word", chan0_offset_word, {mreg[10], mreg[11][15:8]});
        chk("gain_word", chan0_gain_word, {mreg[12], mreg[13][15:8]});
        chk("bus_resp", hresp, 1'b0);
        chk("bus_ready", hreadyout, 1'b1);
        @(posedge clk_sys);
    endtask

    // one raw sample in, corrected sample one cycle later
    task automatic samp(input logic [23:0] d);
        logic [23:0] exp;
        exp = corr(d, {mreg[10], mreg[11][15:8]}, {mreg[12], mreg[13][15:8]});
        mreg[8'h20] = exp[23:8];
        mreg[8'h21] = {exp[7:0], 8'h00};
        chan0_sample_in <= {1'b1, d};
        @(posedge clk_sys);
        chan0_sample_in.valid <= 1'b0;
        #1;
        chk("sample_valid", chan0_sample_out.valid, 1'b1);
        chk("sample_data", chan0_sample_out.data, exp);
        @(posedge clk_sys);
        rdchk(8'h20);
        rdchk(8'h21);
    endtask

    task automatic do_reset();
        rst <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        model_reset();
        @(posedge clk_sys);
    endtask

    // main sequence
    initial
    begin
        do_reset();
        hsel <= 1'b1;
        chk_outs();
        for (int i = 7; i <= 15; i++)
            rdchk(i[7:0]);
        rdchk(8'h30);
        samp(24'h12_3456);
        // random full words, each read straight back, then outputs checked; three rounds
        repeat (3)
        begin
            for (int i = 8; i <= 14; i++)
            begin
                wr(i[7:0], $random(seed));
                rdchk(i[7:0]);
            end
            chk_outs();
        end
        // every select code with both bypass levels on both channels
        for (int s = 0; s < 8; s++)
        begin
            wr(8'h09, ($random(seed) & 32'hffff_fff8) | s);
            wr(8'h0e, ($random(seed) & 32'hffff_fff8) | (7 - s));
            chk_outs();
        end
        // unmapped index and nonzero upper address bits are ignored
        wr(8'h0f, 32'hffff_ffff);
        xfer(1'b1, 32'h0001_0024, 32'hffff_ffff, scratch);
        rdchk(8'h0f);
        rdchk(8'h09);
        chk_outs();
        // correction with random calibration, including saturation
        repeat (20)
        begin
            for (int i = 10; i <= 13; i++)
                wr(i[7:0], $random(seed));
            samp($random(seed));
            samp(24'h80_0000);
        end
        // reset in mid-run restores defaults
        do_reset();
        chk_outs();
        for (int i = 8; i <= 14; i++)
            rdchk(i[7:0]);
        finish_test();
    end

    // watchdog well beyond the expected run length
    initial
    begin
        #(400_000);
        miscompares++;
        finish_test();
    end
endmodule
